// ==== verilog/hsp_serial_port.sv ====
// Host serial control port: shift-clock link logic and core-side register image
// Operation
// [R1] Four lines; transfers accepted only while active-low chip select is low.
// [R2] Serial input sampled on every rising shift-clock edge during a frame.
// [R3] Serial output changes only on falling shift-clock edges.
// [R4] Framing from chip select alone; shift-clock idle level does not matter.
// [R5] Serial output enable high only while returning read data.
// [R6] Never drive output while host still shifts request bits in.
// [R7] A whole transaction fits sixteen clocks under one select assertion.
// [R8] A stretched gap after the eighth clock is harmless.
// [R9] Host sends read request byte then keeps clocking for the data byte.
// [R10] Writes update the addressed register; command locations fire their action.
// [R11] Reads return the current contents of the addressed register.
// [R12] All host data exchange passes through this port only.
// [R13] Write frame: start bit one, seven address bits, eight data bits.
// [R14] Eight data bits always shifted; unused upper bits are ignored.
// [R15] Zero-bit command locations fire regardless of data value.
// [R16] Select high clears the bit counter and discards a partial frame.
// [R17] A write takes effect only after the last data bit is sampled.
`timescale 1ns/1ps
module hsp_serial_port
  import hsp_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              shift_clock,
  input  wire logic              chip_select_n,
  input  wire logic              serial_in,
  output logic                   serial_out,
  output logic                   serial_out_oe,
  input  wire logic [DATA_W-1:0] status_in,
  output logic                   wr_valid,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_data,
  output logic      [CMD_NUM-1:0] cmd_pulse,
  output logic                   watchdog_restart_cmd,
  output logic                   init_done
);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: input shifting on rising edges

  logic [CNT_W-1:0]  bit_cnt_q;
  logic [14:0]       shift_in_q;
  logic              is_read_q;
  logic [ADDR_W-1:0] rd_addr;
  logic              rd_en;
  logic              frame_wr_done;
  logic [ADDR_W-1:0] hold_addr_q;
  logic [DATA_W-1:0] hold_data_q;
  logic              wr_tog_q;
  logic [DATA_W-1:0] mem_rdata;
  logic [DATA_W-1:0] shift_out_q;
  logic              out_oe_q;

  // Select high holds the link logic cleared [R16] [R4]
  always_ff @(posedge shift_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      bit_cnt_q  <= CNT_START;
      shift_in_q <= '0;
      is_read_q  <= 1'b0;
    end
    else
    begin
      shift_in_q <= {shift_in_q[13:0], serial_in}; // [R2] [R13]
      if (bit_cnt_q != CNT_FRAME_END)
      begin
        bit_cnt_q <= bit_cnt_q + 5'h01; // [R7]
      end
      if (bit_cnt_q == CNT_START)
      begin
        is_read_q <= (serial_in != START_WRITE); // [R9]
      end
    end
  end

  // Read address is complete with the eighth rising edge [R9] [R8]
  assign rd_addr = {shift_in_q[5:0], serial_in};
  assign rd_en   = !chip_select_n && (bit_cnt_q == CNT_ADDR_LAST) && !shift_in_q[6];

  // Write completes on the sixteenth sampled bit with select low [R17] [R13]
  assign frame_wr_done = !chip_select_n && (bit_cnt_q == CNT_DATA_LAST)
                         && (shift_in_q[14] == START_WRITE);

  // Completed write is held stable and announced by a toggle [R1] [R12]
  always_ff @(posedge shift_clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_addr_q <= '0;
      hold_data_q <= '0;
      wr_tog_q    <= 1'b0;
    end
    else if (frame_wr_done)
    begin
      hold_addr_q <= shift_in_q[13:7];
      hold_data_q <= {shift_in_q[6:0], serial_in}; // [R14]
      wr_tog_q    <= !wr_tog_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: output shifting on falling edges

  // Output released from the select edge and driven only in data phase [R3] [R5] [R6]
  always_ff @(negedge shift_clock or posedge chip_select_n)
  begin
    if (chip_select_n)
    begin
      shift_out_q <= '0;
      out_oe_q    <= 1'b0;
    end
    else if ((bit_cnt_q == CNT_RD_LOAD) && is_read_q)
    begin
      shift_out_q <= mem_rdata; // [R11]
      out_oe_q    <= 1'b1;
    end
    else if (bit_cnt_q == CNT_FRAME_END)
    begin
      shift_out_q <= '0;
      out_oe_q    <= 1'b0;
    end
    else
    begin
      shift_out_q <= {shift_out_q[6:0], 1'b0}; // [R3]
    end
  end

  assign serial_out    = shift_out_q[7];
  assign serial_out_oe = out_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: reset release and crossings

  logic       rst_s1_q;
  logic       rst_n_q;
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic       tog_s1_q;
  logic       tog_s2_q;
  logic       tog_s3_q;
  logic       wr_evt;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
    end
    else
    begin
      cs_s1_q  <= chip_select_n;
      cs_s2_q  <= cs_s1_q;
      tog_s1_q <= wr_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
    end
  end

  assign wr_evt = tog_s2_q ^ tog_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: register image control

  hsp_state_type     state_q;
  logic [ADDR_W-1:0] init_addr_q;
  logic              pend_q;
  logic              host_go;
  logic              is_cmd;
  logic              snap_go;
  logic [DATA_W-1:0] snap_q;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [DATA_W-1:0] mem_wdata;
  logic              wr_valid_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [DATA_W-1:0] wr_data_q;
  logic [CMD_NUM-1:0] cmd_pulse_q;
  logic              wd_cmd_q;
  logic              init_done_q;

  // Image sweep loads reset values, then normal running
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q     <= HSP_ST_INIT;
      init_addr_q <= '0;
      init_done_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        HSP_ST_INIT:
        begin
          init_addr_q <= init_addr_q + 7'h01;
          if (init_addr_q == '1)
          begin
            state_q     <= HSP_ST_RUN;
            init_done_q <= 1'b1;
          end
        end
        HSP_ST_RUN:
        begin
          state_q <= HSP_ST_RUN;
        end
        default:
        begin
          state_q <= HSP_ST_INIT;
        end
      endcase
    end
  end

  // Pending host write; a new event wins over the clear
  assign host_go = pend_q && (state_q == HSP_ST_RUN);

  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pend_q <= 1'b0;
    end
    else if (wr_evt)
    begin
      pend_q <= 1'b1;
    end
    else if (host_go)
    begin
      pend_q <= 1'b0;
    end
  end

  assign is_cmd  = (hold_addr_q >= ADDR_CMD_FIRST) && (hold_addr_q <= ADDR_CMD_LAST);
  assign snap_go = (state_q == HSP_ST_RUN) && !host_go && cs_s2_q && (status_in != snap_q);

  // Status snapshot follows status_in during the sweep, then changes only while no frame is open [R11]
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      snap_q <= RST_DATA_ZERO;
    end
    else if (snap_go || (state_q == HSP_ST_INIT))
    begin
      snap_q <= status_in;
    end
  end

  // Image write port: sweep, host write, status snapshot
  always_comb
  begin
    mem_we    = 1'b0;
    mem_waddr = init_addr_q;
    mem_wdata = RST_DATA_ZERO;
    if (state_q == HSP_ST_INIT)
    begin
      mem_we    = 1'b1;
      mem_waddr = init_addr_q;
      mem_wdata = (init_addr_q == ADDR_STATUS) ? status_in : hsp_rst_value(init_addr_q);
    end
    else if (host_go && !is_cmd)
    begin
      mem_we    = 1'b1;
      mem_waddr = hold_addr_q;
      mem_wdata = hold_data_q & hsp_sig_mask(hold_addr_q); // [R10] [R14]
    end
    else if (snap_go)
    begin
      mem_we    = 1'b1;
      mem_waddr = ADDR_STATUS;
      mem_wdata = status_in;
    end
  end

  // Register write and command strobes toward the rest of the chip [R10] [R15]
  always_ff @(posedge core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      wr_valid_q  <= 1'b0;
      wr_addr_q   <= '0;
      wr_data_q   <= '0;
      cmd_pulse_q <= '0;
      wd_cmd_q    <= 1'b0;
    end
    else
    begin
      wr_valid_q  <= host_go && !is_cmd;
      cmd_pulse_q <= '0;
      wd_cmd_q    <= host_go && (hold_addr_q == ADDR_WD_RESTART); // [R15]
      if (host_go)
      begin
        wr_addr_q <= hold_addr_q;
        wr_data_q <= hold_data_q & hsp_sig_mask(hold_addr_q); // [R14]
      end
      for (int i = 0; i < CMD_NUM; i++)
      begin
        if (host_go && (hold_addr_q == (ADDR_CMD_FIRST + 7'(i))))
        begin
          cmd_pulse_q[i] <= 1'b1; // [R15]
        end
      end
    end
  end

  assign wr_valid             = wr_valid_q;
  assign wr_addr              = wr_addr_q;
  assign wr_data              = wr_data_q;
  assign cmd_pulse            = cmd_pulse_q;
  assign watchdog_restart_cmd = wd_cmd_q;
  assign init_done            = init_done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register image

  hsp_reg_mem #(
    .AW (ADDR_W),
    .DW (DATA_W)
  ) u_mem (
    .wclk    (core_clk),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (mem_wdata),
    .rclk    (shift_clock),
    .re      (rd_en),
    .raddr   (rd_addr),
    .rdata_q (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_oe_quiet_request;
    @(negedge shift_clock) disable iff (chip_select_n)
      (bit_cnt_q < CNT_RD_LOAD) |-> !out_oe_q;
  endproperty
  a_oe_quiet_request: assert property (p_oe_quiet_request) // [R6]
    else $error("Output driven during request phase");

  property p_oe_read_only;
    @(negedge shift_clock) disable iff (chip_select_n)
      (bit_cnt_q == CNT_RD_LOAD) |=> (out_oe_q == is_read_q);
  endproperty
  a_oe_read_only: assert property (p_oe_read_only) // [R5]
    else $error("Output enable does not follow read request");

  // Output level seen at each rising edge, checked again at the next falling edge
  logic out_at_rise_q;

  always_ff @(posedge shift_clock)
  begin
    out_at_rise_q <= shift_out_q[7];
  end

  property p_out_stable_rise;
    @(negedge shift_clock) disable iff (chip_select_n)
      out_oe_q |-> (shift_out_q[7] == out_at_rise_q);
  endproperty
  a_out_stable_rise: assert property (p_out_stable_rise) // [R3]
    else $error("Serial output changed on rising edge");

  property p_write_toggle;
    @(posedge shift_clock) disable iff (chip_select_n)
      frame_wr_done |=> (wr_tog_q != $past(wr_tog_q));
  endproperty
  a_write_toggle: assert property (p_write_toggle) // [R17]
    else $error("Completed write frame not announced");

  property p_no_toggle_early;
    @(posedge shift_clock) disable iff (chip_select_n)
      (bit_cnt_q < CNT_DATA_LAST) |=> $stable(wr_tog_q);
  endproperty
  a_no_toggle_early: assert property (p_no_toggle_early) // [R17]
    else $error("Write announced before last data bit");

  property p_evt_to_strobe;
    @(posedge core_clk) disable iff (!rst_n_q)
      (wr_evt && (state_q == HSP_ST_RUN) && !pend_q)
        |-> ##[1:2] (wr_valid_q || (cmd_pulse_q != '0));
  endproperty
  a_evt_to_strobe: assert property (p_evt_to_strobe) // [R10]
    else $error("Host write produced no strobe");

  property p_wd_pulse;
    @(posedge core_clk) disable iff (!rst_n_q)
      wd_cmd_q |-> (cmd_pulse_q == 7'h02) ##1 !wd_cmd_q;
  endproperty
  a_wd_pulse: assert property (p_wd_pulse) // [R15]
    else $error("Watchdog restart strobe malformed");

  property p_data_masked;
    @(posedge core_clk) disable iff (!rst_n_q)
      wr_valid_q |-> ((wr_data_q & ~hsp_sig_mask(wr_addr_q)) == 8'h00);
  endproperty
  a_data_masked: assert property (p_data_masked) // [R14]
    else $error("Unused data bits reached a register");

  property p_snap_idle;
    @(posedge core_clk) disable iff (!rst_n_q)
      snap_go |-> cs_s2_q && !pend_q ##1 (snap_q == $past(status_in));
  endproperty
  a_snap_idle: assert property (p_snap_idle) // [R11]
    else $error("Status snapshot taken during a frame");

  c_write_frame: cover property (@(posedge core_clk) disable iff (!rst_n_q) wr_valid_q);
  c_read_frame: cover property (@(negedge shift_clock) disable iff (chip_select_n)
    out_oe_q ##7 out_oe_q);
  c_watchdog: cover property (@(posedge core_clk) disable iff (!rst_n_q) wd_cmd_q);

endmodule // hsp_serial_port

// ==== verilog/hsp_pkg.sv ====
// Package: constants, address map and field helpers of the host serial control port
package hsp_pkg;

  // Frame layout
  localparam int unsigned ADDR_W        = 7;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned CNT_W         = 5;
  localparam logic [4:0]  CNT_START     = 5'h00;
  localparam logic [4:0]  CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0]  CNT_RD_LOAD   = 5'h08;
  localparam logic [4:0]  CNT_DATA_LAST = 5'h0f;
  localparam logic [4:0]  CNT_FRAME_END = 5'h10;
  localparam logic        START_WRITE   = 1'b1;

  // Command locations
  localparam logic [6:0] ADDR_CMD_FIRST = 7'h08;
  localparam logic [6:0] ADDR_CMD_LAST  = 7'h0e;
  localparam logic [6:0] ADDR_WD_RESTART = 7'h09;
  localparam int unsigned CMD_NUM       = 7;

  // Read location of the status snapshot
  localparam logic [6:0] ADDR_STATUS    = 7'h40;

  // Reset values
  localparam logic [7:0] RST_DATA_ZERO  = 8'h00;
  localparam logic [7:0] RST_ADDR_03    = 8'h01;
  localparam logic [7:0] RST_ADDR_1B    = 8'h0f;
  localparam logic [7:0] RST_ADDR_20    = 8'h2b;

  // Significant bit masks
  localparam logic [7:0] MASK_NONE      = 8'h00;
  localparam logic [7:0] MASK_4         = 8'h0f;
  localparam logic [7:0] MASK_5         = 8'h1f;
  localparam logic [7:0] MASK_6         = 8'h3f;
  localparam logic [7:0] MASK_7         = 8'h7f;
  localparam logic [7:0] MASK_8         = 8'hff;

  typedef enum logic [1:0] {
    HSP_ST_INIT = 2'b01,
    HSP_ST_RUN  = 2'b10
  } hsp_state_type;

  function automatic logic [7:0] hsp_sig_mask(input logic [6:0] addr);
    logic [7:0] m;
    m = MASK_8;
    unique case (addr)
      7'h01, 7'h05:                             m = MASK_7;
      7'h02, 7'h04, 7'h14, 7'h19, 7'h1a, 7'h1b: m = MASK_4;
      7'h03:                                    m = MASK_5;
      7'h20:                                    m = MASK_6;
      7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c,
      7'h0d, 7'h0e, 7'h0f, 7'h1d, 7'h1e, 7'h1f: m = MASK_NONE;
      default:                                  m = MASK_8;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] hsp_rst_value(input logic [6:0] addr);
    logic [7:0] v;
    v = RST_DATA_ZERO;
    unique case (addr)
      7'h03:   v = RST_ADDR_03;
      7'h1b:   v = RST_ADDR_1B;
      7'h20:   v = RST_ADDR_20;
      default: v = RST_DATA_ZERO;
    endcase
    return v;
  endfunction

endpackage

// ==== verilog/hsp_reg_mem.sv ====
// Register image memory: core-clock write port, link-clock registered read port
`timescale 1ns/1ps
module hsp_reg_mem #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input  wire logic          wclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          rclk,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem_q [2**AW];

  always_ff @(posedge wclk)
  begin
    if (we)
    begin
      mem_q[waddr] <= wdata;
    end
  end

  always_ff @(posedge rclk)
  begin
    if (re)
    begin
      rdata_q <= mem_q[raddr];
    end
  end

endmodule // hsp_reg_mem

// ==== tb/hsp_host_model.sv ====
// Host microcontroller model driving the four-wire serial port
`timescale 1ns/1ps
module hsp_host_model (
  output logic      chip_select_n,
  output logic      shift_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  initial
  begin
    chip_select_n = 1'b1;
    shift_clock   = 1'b0;
    serial_in     = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: bits set while clock low, read data taken on rising edges
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input int nclk, input logic idle_hi, input int gap,
                      output logic [7:0] q, output int oe_err);
    logic [15:0] sh;
    sh = {~rd, a, d};
    q = 8'h00;
    oe_err = 0;
    shift_clock = idle_hi;
    #40 chip_select_n = 1'b0;
    for (int i = 0; i < nclk; i++)
    begin
      #80 shift_clock = 1'b0;
      // Released line toggles so a stale level is never read as data
      serial_in = ((rd && i >= 8) || i >= 16) ? ~serial_in : sh[15-i];
      if (i == 8) #(gap);
      #80 shift_clock = 1'b1;
      if (rd && i >= 8 && i < 16) q = {q[6:0], serial_out};
      if (serial_out_oe !== (rd && i >= 8 && i < 16)) oe_err++;
    end
    #80 shift_clock = idle_hi;
    #40 chip_select_n = 1'b1;
    serial_in = ~serial_in;
    #1 if (serial_out_oe !== 1'b0) oe_err++;
    #200;
  endtask
endmodule // hsp_host_model

// ==== tb/host_serial_control_port_test.sv ====
// Self-checking bench of the host serial control port
`timescale 1ns/1ps
module host_serial_control_port_test;
  import hsp_pkg::*;
  logic         core_clk;
  logic         arst_n;
  logic         shift_clock;
  logic         chip_select_n;
  logic         serial_in;
  logic         serial_out;
  logic         serial_out_oe;
  logic [7:0]   status_in;
  logic         wr_valid;
  logic [6:0]   wr_addr;
  logic [7:0]   wr_data;
  logic [6:0]   cmd_pulse;
  logic         watchdog_restart_cmd;
  logic         init_done;
  int           error_cnt;
  int           cmp_count;
  int           cyc;
  int           seed;
  int           wv_cnt;
  int           wd_cnt;
  int           cp_cnt [7];
  logic [7:0]   img [128];

  hsp_serial_port u_hsp_serial_port (
    .core_clk(core_clk), .arst_n(arst_n), .shift_clock(shift_clock),
    .chip_select_n(chip_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .status_in(status_in), .wr_valid(wr_valid),
    .wr_addr(wr_addr), .wr_data(wr_data), .cmd_pulse(cmd_pulse),
    .watchdog_restart_cmd(watchdog_restart_cmd), .init_done(init_done));

  hsp_host_model u_hsp_host_model (
    .chip_select_n(chip_select_n), .shift_clock(shift_clock), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe counters and hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (wr_valid === 1'b1) wv_cnt++;
    if (watchdog_restart_cmd === 1'b1) wd_cnt++;
    for (int i = 0; i < 7; i++)
      if (cmd_pulse[i] === 1'b1) cp_cnt[i]++;
    if (cyc == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Significant data bits of each address
  function automatic logic [7:0] sig_mask(input logic [6:0] a);
    case (a)
      7'h01, 7'h05: return 8'h7f;
      7'h02, 7'h04, 7'h14, 7'h19, 7'h1a, 7'h1b: return 8'h0f;
      7'h03: return 8'h1f;
      7'h20: return 8'h3f;
      7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h1d, 7'h1e, 7'h1f:
        return 8'h00;
      default: return 8'hff;
    endcase
  endfunction

  task automatic do_reset();
    arst_n = 1'b0;
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 128; i++) img[i] = 8'h00;
    img[3] = 8'h01;
    img[27] = 8'h0f;
    img[32] = 8'h2b;
    for (int i = 0; i < 300 && init_done !== 1'b1; i++) @(negedge core_clk);
    chk({7'h00, init_done}, 8'h01);
  endtask

  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input int nclk, output logic [7:0] q);
    int e;
    @(negedge core_clk);
    u_hsp_host_model.xfer(rd, a, d, nclk, $random(seed) & 1, ($random(seed) & 1) * 400, q, e);
    chk(8'(e), 8'h00);
  endtask

  task automatic do_read(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    xfer(1'b1, a, 8'($random(seed)), 16, q);
    chk(q, exp);
  endtask

  task automatic do_write(input logic [6:0] a, input logic [7:0] d, input int nclk);
    logic [7:0] q;
    int wv0;
    int wd0;
    int cp0;
    logic cmd;
    wv0 = wv_cnt;
    wd0 = wd_cnt;
    cmd = (a >= 7'h08 && a <= 7'h0e);
    cp0 = cmd ? cp_cnt[a - 7'h08] : 0;
    xfer(1'b0, a, d, nclk, q);
    repeat (8) @(negedge core_clk);
    if (nclk < 16)
    begin
      chk(8'(wv_cnt - wv0), 8'h00);
      return;
    end
    chk(8'(wv_cnt - wv0), cmd ? 8'h00 : 8'h01);
    if (cmd) chk(8'(cp_cnt[a - 7'h08] - cp0), 8'h01);
    chk(8'(wd_cnt - wd0), (a == 7'h09) ? 8'h01 : 8'h00);
    chk({1'b0, wr_addr}, {1'b0, a});
    if (!cmd) chk(wr_data, d & sig_mask(a));
    img[a] = d & sig_mask(a);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    seed = 6455;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    wv_cnt = 0;
    wd_cnt = 0;
    for (int i = 0; i < 7; i++) cp_cnt[i] = 0;
    status_in = 8'h00;
    do_reset();
    foreach (img[i]) if (i < 34) do_read(7'(i), img[i]);
    for (int i = 8; i <= 14; i++) do_write(7'(i), 8'($random(seed)), 16);
    for (int i = 0; i < 20; i++)
    begin
      a = 7'($random(seed)) & 7'h3f;
      d = 8'($random(seed));
      do_write(a, d, 16);
      do_read(a, img[a]);
    end
    a = 7'h10;
    do_write(a, 8'h5a, 10);
    do_write(a, 8'ha5, 15);
    do_read(a, img[a]);
    do_write(7'h06, 8'h3c, 20);
    do_read(7'h06, 8'h3c);
    for (int i = 0; i < 3; i++)
    begin
      @(negedge core_clk);
      status_in = 8'($random(seed));
      repeat (4) @(negedge core_clk);
      do_read(ADDR_STATUS, status_in);
    end
    do_write(7'h03, 8'hff, 16);
    do_reset();
    do_read(7'h03, 8'h01);
    do_read(7'h20, 8'h2b);
    report_and_stop();
  end
endmodule // host_serial_control_port_test
